/* inc/ifr_pkg.sv */
package ifr_pkg;

  // ==========================================================
  // Control-method codes
  // ==========================================================
  localparam logic [3:0] CM_SPEED      = 4'h0;
  localparam logic [3:0] CM_POSITION   = 4'h1;
  localparam logic [3:0] CM_TORQUE     = 4'h2;
  localparam logic [3:0] CM_INT_SPEED  = 4'h3;
  localparam logic [3:0] CM_INT_SPD    = 4'h4;
  localparam logic [3:0] CM_INT_POS    = 4'h5;
  localparam logic [3:0] CM_INT_TRQ    = 4'h6;
  localparam logic [3:0] CM_POS_SPD    = 4'h7;
  localparam logic [3:0] CM_POS_TRQ    = 4'h8;
  localparam logic [3:0] CM_TRQ_SPD    = 4'h9;
  localparam logic [3:0] CM_SPD_ZERO_CLAMP_IN = 4'ha;
  localparam logic [3:0] CM_POS_INHIB  = 4'hb;
  localparam logic [3:0] CM_LAST       = 4'hb;

  // ==========================================================
  // Input line positions within the 7-bit bundle (lines 40..46)
  // ==========================================================
  localparam int LINE40 = 0;
  localparam int LINE41 = 1;
  localparam int LINE42 = 2;
  localparam int LINE43 = 3;
  localparam int LINE44 = 4;
  localparam int LINE45 = 5;
  localparam int LINE46 = 6;
  localparam int NUM_LINES = 7;

  // ==========================================================
  // Register map (AHB-Lite, byte addresses)
  // ==========================================================
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_FUNCS   = 8'h08;
  localparam logic [3:0] CONTROL_RESET = 4'h0;

  // Status bit positions
  localparam int ST_BASEBLOCK = 0;
  localparam int ST_MONITOR   = 1;
  localparam int ST_CM_VALID  = 2;
  localparam int ST_SECOND    = 3;

  // Running method as one-hot
  typedef enum logic [3:0] {
    RUN_SPEED    = 4'b0001,
    RUN_POSITION = 4'b0010,
    RUN_TORQUE   = 4'b0100,
    RUN_INTSPEED = 4'b1000
  } ifr_run_type;

  // Decoded functions
  typedef struct packed {
    logic servoOn;
    logic fwdRunProhibit;
    logic revRunProhibit;
    logic alarmClearIn;
    logic proportionalOpIn;
    logic fwdTorqueLimitIn;
    logic revTorqueLimitIn;
    logic rotationDirSelect;
    logic speedSelectA;
    logic speedSelectB;
    logic methodSwitch;
    logic zeroClampIn;
    logic pulseInhibit;
  } ifr_func_type;

endpackage

/* rtl/ifr_method_decode.sv */
`timescale 1ns/1ps

// Maps the 4-bit control-method code and the switch level to the
// method actually running; purely combinational.
module ifr_method_decode (
  input  wire logic [3:0]          code,
  input  wire logic                switchActive,
  output ifr_pkg::ifr_run_type     runMethod,
  output logic                     codeValid,
  output logic                     secondActive
);

  // ==========================================================
  // Pair selection
  // ==========================================================
  // First listed method while switch inactive, second while active
  always_comb begin
    codeValid    = 1'b1;
    secondActive = 1'b0;
    runMethod    = ifr_pkg::RUN_SPEED;
    unique case (code)
      ifr_pkg::CM_SPEED:      runMethod = ifr_pkg::RUN_SPEED;
      ifr_pkg::CM_POSITION:   runMethod = ifr_pkg::RUN_POSITION;
      ifr_pkg::CM_TORQUE:     runMethod = ifr_pkg::RUN_TORQUE;
      ifr_pkg::CM_INT_SPEED:  runMethod = ifr_pkg::RUN_INTSPEED;
      ifr_pkg::CM_INT_SPD: begin
        secondActive = switchActive;
        runMethod = switchActive ? ifr_pkg::RUN_SPEED : ifr_pkg::RUN_INTSPEED;
      end
      ifr_pkg::CM_INT_POS: begin
        secondActive = switchActive;
        runMethod = switchActive ? ifr_pkg::RUN_POSITION : ifr_pkg::RUN_INTSPEED;
      end
      ifr_pkg::CM_INT_TRQ: begin
        secondActive = switchActive;
        runMethod = switchActive ? ifr_pkg::RUN_TORQUE : ifr_pkg::RUN_INTSPEED;
      end
      ifr_pkg::CM_POS_SPD: begin
        secondActive = switchActive;
        runMethod = switchActive ? ifr_pkg::RUN_SPEED : ifr_pkg::RUN_POSITION;
      end
      ifr_pkg::CM_POS_TRQ: begin
        secondActive = switchActive;
        runMethod = switchActive ? ifr_pkg::RUN_TORQUE : ifr_pkg::RUN_POSITION;
      end
      ifr_pkg::CM_TRQ_SPD: begin
        secondActive = switchActive;
        runMethod = switchActive ? ifr_pkg::RUN_SPEED : ifr_pkg::RUN_TORQUE;
      end
      // Zero clamp and pulse inhibit keep the base method running
      ifr_pkg::CM_SPD_ZERO_CLAMP_IN: begin
        secondActive = switchActive;
        runMethod = ifr_pkg::RUN_SPEED;
      end
      ifr_pkg::CM_POS_INHIB: begin
        secondActive = switchActive;
        runMethod = ifr_pkg::RUN_POSITION;
      end
      default: codeValid = 1'b0; // Codes C..F are unused: fall back to speed
    endcase
  end

endmodule

/* rtl/input_function_router.sv */
`timescale 1ns/1ps

module input_function_router (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  input  wire logic [6:0]           inputLines,
  input  wire logic                 safety_block_in_a,
  input  wire logic                 safety_block_in_b,
  input  wire logic                 baseblockConfirmed,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  output ifr_pkg::ifr_func_type     funcs_r,
  output ifr_pkg::ifr_run_type      runMethod_r,
  output logic                      baseblock_r,
  output logic                      safety_monitor_out
);

  // ==========================================================
  // Configuration register
  // ==========================================================
  logic [3:0]  control_method_field;
  logic        wrPending_r;
  logic [7:0]  wrAddr_r;
  logic        rdPending_r;
  logic [7:0]  rdAddr_r;
  logic        addrPhase;

  assign addrPhase = hsel && hready && htrans[1];

  // Capture the address phase; writes complete in the next cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPending_r <= 1'b0;
      rdPending_r <= 1'b0;
      wrAddr_r    <= 8'h00;
      rdAddr_r    <= 8'h00;
    end else if (clkEn) begin
      wrPending_r <= addrPhase && hwrite;
      rdPending_r <= addrPhase && !hwrite;
      wrAddr_r    <= haddr[7:0];
      rdAddr_r    <= haddr[7:0];
    end
  end

  // Only the control word is writable; other offsets ignore writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      control_method_field <= ifr_pkg::CONTROL_RESET;
    end else if (clkEn && wrPending_r && wrAddr_r == ifr_pkg::ADDR_CONTROL) begin
      control_method_field <= hwdata[3:0];
    end
  end

  // ==========================================================
  // Line routing
  // ==========================================================
  // The line-to-signal assignment is fixed; only the meaning of
  // lines 41, 45 and 46 follows the method code.
  logic l41;
  logic l45;
  logic l46;
  logic isIntSpeedGroup;
  logic isBasicGroup;
  logic isSwitchGroup;
  ifr_pkg::ifr_func_type funcs_nxt;

  assign l41 = inputLines[ifr_pkg::LINE41];
  assign l45 = inputLines[ifr_pkg::LINE45];
  assign l46 = inputLines[ifr_pkg::LINE46];

  assign isBasicGroup    = control_method_field <= ifr_pkg::CM_TORQUE;
  assign isIntSpeedGroup = control_method_field >= ifr_pkg::CM_INT_SPEED &&
                           control_method_field <= ifr_pkg::CM_INT_TRQ;
  assign isSwitchGroup   = control_method_field >= ifr_pkg::CM_POS_SPD &&
                           control_method_field <= ifr_pkg::CM_LAST;

  always_comb begin
    funcs_nxt = '0;
    // Fixed lines in every method
    funcs_nxt.servoOn        = inputLines[ifr_pkg::LINE40];
    funcs_nxt.fwdRunProhibit = inputLines[ifr_pkg::LINE42];
    funcs_nxt.revRunProhibit = inputLines[ifr_pkg::LINE43];
    funcs_nxt.alarmClearIn   = inputLines[ifr_pkg::LINE44];
    if (isBasicGroup) begin
      funcs_nxt.proportionalOpIn = l41;
      funcs_nxt.fwdTorqueLimitIn = l45;
      funcs_nxt.revTorqueLimitIn = l46;
    end else if (isIntSpeedGroup) begin
      funcs_nxt.rotationDirSelect = l41;
      funcs_nxt.speedSelectA      = l45;
      funcs_nxt.speedSelectB      = l46;
    end else if (isSwitchGroup) begin
      funcs_nxt.fwdTorqueLimitIn = l45;
      funcs_nxt.revTorqueLimitIn = l46;
      if (control_method_field == ifr_pkg::CM_SPD_ZERO_CLAMP_IN) begin
        funcs_nxt.zeroClampIn = l41;
      end else if (control_method_field == ifr_pkg::CM_POS_INHIB) begin
        funcs_nxt.pulseInhibit = l41;
      end else begin
        funcs_nxt.methodSwitch = l41;
      end
    end
  end

  // Routed functions registered; no remapping state exists
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      funcs_r <= '0;
    end else if (clkEn) begin
      funcs_r <= funcs_nxt;
    end
  end

  // ==========================================================
  // Method selection
  // ==========================================================
  ifr_pkg::ifr_run_type runMethod;
  logic codeValid;
  logic secondActive;
  logic secondActive_r;
  logic codeValid_r;

  // Paired codes switch on line 41; it carries methodSwitch for codes 7..9 but rotationDirSelect for codes 4..6
  ifr_method_decode ifr_method_decode_inst (
    .code         (control_method_field),
    .switchActive (l41),
    .runMethod    (runMethod),
    .codeValid    (codeValid),
    .secondActive (secondActive)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      runMethod_r    <= ifr_pkg::RUN_SPEED;
      secondActive_r <= 1'b0;
      codeValid_r    <= 1'b1;
    end else if (clkEn) begin
      runMethod_r    <= runMethod;
      secondActive_r <= secondActive;
      codeValid_r    <= codeValid;
    end
  end

  // ==========================================================
  // Safety baseblock
  // ==========================================================
  // Baseblock held in reset too, so the motor is never live early
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      baseblock_r <= 1'b1;
    end else if (clkEn) begin
      baseblock_r <= !(safety_block_in_a && safety_block_in_b);
    end
  end

  // Monitor needs both channels requesting the block and the power stage confirming;
  // the safety device reads it to prove that neither channel is stuck on
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      safety_monitor_out <= 1'b0;
    end else if (clkEn) begin
      safety_monitor_out <= !safety_block_in_a && !safety_block_in_b &&
                            baseblockConfirmed;
    end
  end

  // ==========================================================
  // Bus answers
  // ==========================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (clkEn) begin
      hrdata <= 32'h0000_0000;
      if (addrPhase && !hwrite) begin
        unique case (haddr[7:0])
          ifr_pkg::ADDR_CONTROL: hrdata <= {28'h0000000, control_method_field};
          ifr_pkg::ADDR_STATUS: begin
            hrdata[ifr_pkg::ST_BASEBLOCK] <= baseblock_r;
            hrdata[ifr_pkg::ST_MONITOR]   <= safety_monitor_out;
            hrdata[ifr_pkg::ST_CM_VALID]  <= codeValid_r;
            hrdata[ifr_pkg::ST_SECOND]    <= secondActive_r;
            hrdata[7:4]                   <= runMethod_r;
          end
          ifr_pkg::ADDR_FUNCS: hrdata <= {19'h00000, funcs_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Zero-wait slave; response always OKAY
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clkEn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

/* verification/ifr_assertions.sv */
`timescale 1ns/1ps
// ==========================================
// Port checker, bound into the router
module ifr_assertions (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  clkEn,
  input wire logic [6:0]            inputLines,
  input wire logic                  safety_block_in_a,
  input wire logic                  safety_block_in_b,
  input wire logic                  baseblockConfirmed,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire ifr_pkg::ifr_func_type funcs_r,
  input wire ifr_pkg::ifr_run_type  runMethod_r,
  input wire logic                  baseblock_r,
  input wire logic                  safety_monitor_out
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_block_forces_off: assert property (clkEn && !(safety_block_in_a && safety_block_in_b)
    |=> baseblock_r && (!safety_monitor_out || $past(!safety_block_in_a && !safety_block_in_b)))
    else $error("baseblock not forced");
  a_monitor_needs_all: assert property (clkEn |=> safety_monitor_out ==
    $past(!safety_block_in_a && !safety_block_in_b && baseblockConfirmed)) else $error("monitor");
  a_fixed_lines: assert property (clkEn |=> {funcs_r.servoOn, funcs_r.fwdRunProhibit,
    funcs_r.revRunProhibit, funcs_r.alarmClearIn} == $past({inputLines[0], inputLines[2],
    inputLines[3], inputLines[4]})) else $error("fixed line functions wrong");
  a_line45_source: assert property (clkEn && !inputLines[5]
    |=> !funcs_r.fwdTorqueLimitIn && !funcs_r.speedSelectA) else $error("line 45 leak");
  a_line46_source: assert property (clkEn && !inputLines[6]
    |=> !funcs_r.revTorqueLimitIn && !funcs_r.speedSelectB) else $error("line 46 leak");
  // Lines 41 and 45 each feed at most one function at a time
  a_one_function: assert property ($onehot0({funcs_r.proportionalOpIn,
    funcs_r.rotationDirSelect, funcs_r.methodSwitch, funcs_r.zeroClampIn, funcs_r.pulseInhibit})
    && $onehot0({funcs_r.fwdTorqueLimitIn, funcs_r.speedSelectA})) else $error("shared line");
  a_run_onehot: assert property ($onehot(runMethod_r)) else $error("run method not one-hot");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error");
  a_read_idle: assert property (clkEn && !(hsel && htrans[1]) |=> hrdata == 32'h0)
    else $error("read data left standing");
endmodule

/* verification/ifr_far_side.sv */
`timescale 1ns/1ps
// ==========================================
// Contacts, safety device and power stage; levels change only on a clock edge
module ifr_far_side (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [6:0] lineReq,
  input  wire logic [2:0] safeReq,
  output logic [6:0]      inputLines,
  output logic            safety_block_in_a,
  output logic            safety_block_in_b,
  output logic            baseblockConfirmed
);
  // Channels start off, so the drive powers up blocked
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      inputLines <= 7'h00;
      {baseblockConfirmed, safety_block_in_b, safety_block_in_a} <= 3'h0;
    end else begin
      inputLines <= lineReq;
      {baseblockConfirmed, safety_block_in_b, safety_block_in_a} <= safeReq;
    end
  end
endmodule

/* verification/input_function_router_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
// ==========================================
// Bench top
module input_function_router_tb;
  logic clk_sys = 0, rst = 1, clkEn = 1, hsel = 0, hwrite = 0;
  logic [6:0] lineReq = 7'h00;
  logic [2:0] safeReq = 3'h0, hsize = 3'h2;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire logic [6:0] inputLines;
  wire logic sa, sb, conf, hreadyout, hresp, bb, mon;
  wire logic [31:0] hrdata;
  wire ifr_pkg::ifr_func_type funcs_r;
  wire ifr_pkg::ifr_run_type runMethod_r;
  int n_fail = 0, tests_run = 0;

  ifr_far_side ifr_far_side_inst (.clk_sys(clk_sys), .rst(rst), .lineReq(lineReq),
    .safeReq(safeReq), .inputLines(inputLines), .safety_block_in_a(sa),
    .safety_block_in_b(sb), .baseblockConfirmed(conf));
  input_function_router input_function_router_inst (.clk_sys(clk_sys), .rst(rst),
    .clkEn(clkEn), .inputLines(inputLines), .safety_block_in_a(sa), .safety_block_in_b(sb),
    .baseblockConfirmed(conf), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .funcs_r(funcs_r), .runMethod_r(runMethod_r),
    .baseblock_r(bb), .safety_monitor_out(mon));

  // Free-running system clock
  initial forever #10 clk_sys = ~clk_sys;

  task test_done;
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Single word transfer; entered just after a rising edge
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= wr;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: address phase timeout", $time);
      test_done();
    end
    hsel <= 0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (hreadyout !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: data phase timeout", $time);
      test_done();
    end
  endtask

  task chk_reset;
    `CHK(funcs_r, 13'h0)
    `CHK(runMethod_r, ifr_pkg::RUN_SPEED)
    `CHK(bb, 1'b1)
    `CHK(mon, 1'b0)
  endtask

  // Every code with four patterns on lines 41, 45 and 46
  task t_methods;
    ifr_pkg::ifr_func_type e;
    ifr_pkg::ifr_run_type run;
    logic v, s, l1, l5;
    for (int c = 0; c < 16; c++) for (int l = 0; l < 4; l++) begin
      l1 = l[0]; l5 = l[1];
      lineReq <= {~l5, l5, 3'b010, l1, 1'b1};
      ahb(1, ifr_pkg::ADDR_CONTROL, c);
      repeat (2) @(posedge clk_sys);
      v = c <= 11; s = v && c >= 4 && l1;
      e = '0; e.servoOn = 1; e.revRunProhibit = 1;
      if (c <= 2) {e.proportionalOpIn, e.fwdTorqueLimitIn, e.revTorqueLimitIn} = {l1, l5, ~l5};
      else if (c <= 6) {e.rotationDirSelect, e.speedSelectA, e.speedSelectB} = {l1, l5, ~l5};
      else if (v) begin
        {e.fwdTorqueLimitIn, e.revTorqueLimitIn} = {l5, ~l5};
        if (c <= 9) e.methodSwitch = l1; else if (c == 10) e.zeroClampIn = l1;
        else e.pulseInhibit = l1;
      end
      case (c)
        1, 11: run = ifr_pkg::RUN_POSITION;
        2: run = ifr_pkg::RUN_TORQUE;
        3: run = ifr_pkg::RUN_INTSPEED;
        4: run = s ? ifr_pkg::RUN_SPEED : ifr_pkg::RUN_INTSPEED;
        5: run = s ? ifr_pkg::RUN_POSITION : ifr_pkg::RUN_INTSPEED;
        6: run = s ? ifr_pkg::RUN_TORQUE : ifr_pkg::RUN_INTSPEED;
        7: run = s ? ifr_pkg::RUN_SPEED : ifr_pkg::RUN_POSITION;
        8: run = s ? ifr_pkg::RUN_TORQUE : ifr_pkg::RUN_POSITION;
        9: run = s ? ifr_pkg::RUN_SPEED : ifr_pkg::RUN_TORQUE;
        default: run = ifr_pkg::RUN_SPEED;
      endcase
      `CHK(funcs_r, e)
      `CHK(runMethod_r, run)
      ahb(0, ifr_pkg::ADDR_STATUS, 0);
      `CHK(rd[7:2], {run, s, v})
    end
  endtask

  // All eight combinations of both channels and the power stage report
  task t_safety;
    for (int k = 0; k < 8; k++) begin
      safeReq <= k[2:0];
      repeat (3) @(posedge clk_sys);
      `CHK(bb, !(k[0] && k[1]))
      `CHK(mon, !k[0] && !k[1] && k[2])
      ahb(0, ifr_pkg::ADDR_STATUS, 0);
      `CHK(rd[1], !k[0] && !k[1] && k[2])
      `CHK(rd[0], !(k[0] && k[1]))
    end
  endtask

  // Clock enable low holds baseblock and servoOn while the far side moves
  task t_freeze;
    clkEn <= 0;
    safeReq <= 3'h0;
    lineReq <= 7'h00;
    repeat (3) @(posedge clk_sys);
    `CHK(bb, 1'b0)
    `CHK(funcs_r.servoOn, 1'b1)
    clkEn <= 1;
    repeat (2) @(posedge clk_sys);
    `CHK(bb, 1'b1)
    `CHK(funcs_r.servoOn, 1'b0)
  endtask

  // Read-only offsets ignore writes; a hole reads zero
  task t_bus;
    ifr_pkg::ifr_func_type e;
    lineReq <= 7'h7f;
    ahb(1, ifr_pkg::ADDR_CONTROL, 32'h5);
    ahb(1, ifr_pkg::ADDR_STATUS, 32'hf);
    ahb(1, ifr_pkg::ADDR_FUNCS, 32'hf);
    ahb(0, ifr_pkg::ADDR_CONTROL, 0);
    `CHK(rd, 32'h5)
    ahb(0, ifr_pkg::ADDR_FUNCS, 0);
    e = '0;
    {e.servoOn, e.fwdRunProhibit, e.revRunProhibit, e.alarmClearIn} = 4'hf;
    {e.rotationDirSelect, e.speedSelectA, e.speedSelectB} = 3'h7;
    `CHK(rd, {19'h00000, e})
    ahb(0, 8'h0c, 0);
    `CHK(rd, 32'h0)
  endtask

  // Main sequence, with a second reset in mid-run
  initial begin
    repeat (16) @(posedge clk_sys);
    chk_reset();
    rst <= 0;
    @(posedge clk_sys);
    t_methods();
    t_safety();
    t_freeze();
    t_bus();
    rst <= 1;
    repeat (3) @(posedge clk_sys);
    chk_reset();
    rst <= 0;
    @(posedge clk_sys);
    ahb(0, ifr_pkg::ADDR_CONTROL, 0);
    `CHK(rd, 32'h0)
    test_done();
  end
endmodule

bind input_function_router ifr_assertions ifr_assertions_inst (.clk_sys(clk_sys), .rst(rst),
  .clkEn(clkEn), .inputLines(inputLines), .safety_block_in_a(safety_block_in_a),
  .safety_block_in_b(safety_block_in_b), .baseblockConfirmed(baseblockConfirmed),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .funcs_r(funcs_r), .runMethod_r(runMethod_r), .baseblock_r(baseblock_r),
  .safety_monitor_out(safety_monitor_out));
